// ===== pkg/iotrg_consts.vh
`ifndef IOTRG_CONSTS_VH
`define IOTRG_CONSTS_VH

// clock and scan timing
`define IOTRG_CLK_PERIOD_NS 10
`define IOTRG_SCAN_PERIOD_MS 100
`define IOTRG_SCAN_CYCLES ((`IOTRG_SCAN_PERIOD_MS * 1000000) / `IOTRG_CLK_PERIOD_NS)

// bank geometry
`define IOTRG_PORT_COUNT 3
`define IOTRG_PORT_WIDTH 8
`define IOTRG_BANK_WIDTH 24
`define IOTRG_BASE_WIDTH 16

// register byte offsets
`define IOTRG_ADDR_PORT0 8'h00
`define IOTRG_ADDR_PORT1 8'h04
`define IOTRG_ADDR_PORT2 8'h08
`define IOTRG_ADDR_DIR 8'h0C
`define IOTRG_ADDR_BITWR 8'h10
`define IOTRG_ADDR_INSEL 8'h14
`define IOTRG_ADDR_INREAD 8'h18
`define IOTRG_ADDR_CACHE 8'h1C
`define IOTRG_ADDR_TRIG 8'h20
`define IOTRG_ADDR_CTRL 8'h24
`define IOTRG_ADDR_IRQ_STAT 8'h28
`define IOTRG_ADDR_IRQ_MASK 8'h2C

// single-bit write fields
`define IOTRG_BITWR_BIT_LSB 0
`define IOTRG_BITWR_PORT_LSB 4
`define IOTRG_BITWR_VAL_BIT 8

// input selector register fields
`define IOTRG_INSEL_SRC_LSB 0
`define IOTRG_INSEL_MASK_LSB 8
`define IOTRG_INSEL_MAX 3'h4
`define IOTRG_INSEL_MASK_RST 24'hFFFFFF

// trigger configuration fields
`define IOTRG_TRIG_ACT_LSB 0
`define IOTRG_TRIG_POL_BIT 3
`define IOTRG_TRIG_IDX_LSB 4
`define IOTRG_TRIG_BOARD_LSB 8
`define IOTRG_BOARD_MIN 3'h1
`define IOTRG_BOARD_MAX 3'h6
`define IOTRG_BOARD_BASE 3'h1

// trigger action codes
`define IOTRG_ACT_OFF 3'h0
`define IOTRG_ACT_JMP_ABORT 3'h1
`define IOTRG_ACT_JMP 3'h2
`define IOTRG_ACT_JMP_OFF 3'h3
`define IOTRG_ACT_JMP_OFF_ABORT 3'h4

// interrupt status bits
`define IOTRG_IRQ_FIRED 0
`define IOTRG_IRQ_SCAN 1
`define IOTRG_IRQ_WIDTH 2

`endif

// ===== core/iotrg_scan_timer.v
`timescale 1ns/1ps
`default_nettype none

// free-running period tick, one-cycle pulse each PERIOD enabled cycles
module iotrg_scan_timer #(
   parameter integer PERIOD = 10000000,
   parameter integer CNT_W = 24
) (
   input wire mclk,
   input wire sys_rst,
   input wire ce,
   output reg tick_ff
);

   localparam integer LAST_I = PERIOD - 1;

   reg [CNT_W-1:0] count_ff;

   always @(posedge mclk) begin
      if (sys_rst) begin
         count_ff <= {CNT_W{1'b0}};
         tick_ff <= 1'b0;
      end else if (ce) begin
         if (count_ff == LAST_I[CNT_W-1:0]) begin
            count_ff <= {CNT_W{1'b0}};
            tick_ff <= 1'b1;
         end else begin
            count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_ff <= 1'b0;
         end
      end
   end

endmodule // iotrg_scan_timer

`default_nettype wire

// ===== core/iotrg_top.v
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iotrg_consts.vh"

// How it works
// - expansion bank has 24 bits arranged as three 8-bit ports.
// - each port's direction is set on its own, whole port at once.
// - outputs are active low; stored one pulls the pin to ground.
// - stored zero leaves the output pin high impedance.
// - reset makes every expansion bit an input with pins released.
// - whole-port write of 0 to 255 to port index 0 to 2.
// - single-bit write changes only the addressed bit of the port.
// - selector zero returns the live 16 base-card inputs, not a cache.
// - selector 0 to 4 picks base card or expansion groups.
// - a mask returns only the requested bits 0 to 23.
// - cached input status word refreshes once every 100 ms.
// - trigger input is sampled once every 100 ms.
// - trigger fires when sampled level equals configured polarity.
// - action 0 off, 1 jump+abort, 2 jump, 3 jump+off, 4 all.
// - trigger index 0 to 15, board number 1 to 6.
// - trigger is evaluated only while a user program runs.
// - direction zero is input, one output; ports 0,1,2 are A,B,C.
// - output data written before direction is held and driven later.
module iotrg_top #(
   parameter integer SCAN_CYCLES = `IOTRG_SCAN_CYCLES,
   parameter integer SCAN_CNT_W = 24
) (
   input wire mclk,
   input wire sys_rst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_ff,
   input wire [15:0] base_in,
   input wire [23:0] exp_in,
   output wire [23:0] exp_out,
   output reg [23:0] exp_oe_ff,
   output reg trig_jump_ff,
   output reg trig_abort_ff,
   output wire irq
);

   localparam integer NPIN = `IOTRG_BASE_WIDTH + `IOTRG_BANK_WIDTH;

   // pin synchroniser, three stages per pin
   wire [NPIN-1:0] pin_raw;
   reg [NPIN-1:0] sync1_ff;
   reg [NPIN-1:0] sync2_ff;
   reg [NPIN-1:0] sync3_ff;
   reg [NPIN-1:0] pin_ff;
   wire [NPIN-1:0] nxt_pin;

   // bank state
   reg [23:0] out_data_ff;
   reg [2:0] port_direction_set_ff;
   reg [23:0] nxt_out_data;
   reg [2:0] nxt_dir;

   // input read path
   reg [2:0] input_read_selector_ff;
   reg [23:0] input_mask_ff;
   reg [23:0] cached_input_status_ff;
   reg [23:0] in_source;

   // trigger configuration
   reg [2:0] trigger_action_ff;
   reg trigger_polarity_ff;
   reg [3:0] trigger_input_index_ff;
   reg [2:0] trigger_board_ff;
   reg prog_running_ff;
   reg [2:0] nxt_action;

   // interrupt block
   reg [`IOTRG_IRQ_WIDTH-1:0] irq_stat_ff;
   reg [`IOTRG_IRQ_WIDTH-1:0] irq_mask_ff;
   reg [`IOTRG_IRQ_WIDTH-1:0] irq_event;
   reg [`IOTRG_IRQ_WIDTH-1:0] nxt_irq_stat;

   wire scan_tick;
   wire [23:0] base_live;
   wire [23:0] exp_live;
   wire trig_sample;
   wire trig_fire;
   reg [31:0] rd_mux;

   // bit-write, selector and trigger decode helpers
   wire [2:0] bw_bit;
   wire [1:0] bw_port;
   wire bw_val;
   wire [4:0] bw_index;
   wire [2:0] wsel;
   wire [2:0] wboard;
   wire [2:0] wact;

   assign pin_raw = {exp_in, base_in};

   // a change only counts once two late stages agree, filters one-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
         assign nxt_pin[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : pin_ff[gi];
      end
   endgenerate

   always @(posedge mclk) begin
      if (sys_rst) begin
         sync1_ff <= {NPIN{1'b0}};
         sync2_ff <= {NPIN{1'b0}};
         sync3_ff <= {NPIN{1'b0}};
         pin_ff <= {NPIN{1'b0}};
      end else if (ce) begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pin_ff <= nxt_pin;
      end
   end

   // synchroniser and filter together cost four cycles of latency on every pin
   assign base_live = {8'h00, pin_ff[`IOTRG_BASE_WIDTH-1:0]};
   assign exp_live = pin_ff[NPIN-1:`IOTRG_BASE_WIDTH];

   iotrg_scan_timer #(
      .PERIOD(SCAN_CYCLES),
      .CNT_W(SCAN_CNT_W)
   ) u_scan (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick_ff(scan_tick)
   );

   assign bw_bit = reg_wdata[`IOTRG_BITWR_BIT_LSB +: 3];
   assign bw_port = reg_wdata[`IOTRG_BITWR_PORT_LSB +: 2];
   assign bw_val = reg_wdata[`IOTRG_BITWR_VAL_BIT];
   assign bw_index = {bw_port, bw_bit};
   assign wsel = reg_wdata[`IOTRG_INSEL_SRC_LSB +: 3];
   assign wboard = reg_wdata[`IOTRG_TRIG_BOARD_LSB +: 3];
   assign wact = reg_wdata[`IOTRG_TRIG_ACT_LSB +: 3];

   // output data and direction; data is kept whatever the direction
   always @* begin
      nxt_out_data = out_data_ff;
      nxt_dir = port_direction_set_ff;
      if (reg_wr) begin
         if (reg_addr == `IOTRG_ADDR_PORT0) begin
            nxt_out_data[7:0] = reg_wdata[7:0];
         end else if (reg_addr == `IOTRG_ADDR_PORT1) begin
            nxt_out_data[15:8] = reg_wdata[7:0];
         end else if (reg_addr == `IOTRG_ADDR_PORT2) begin
            nxt_out_data[23:16] = reg_wdata[7:0];
         end else if (reg_addr == `IOTRG_ADDR_BITWR) begin
            // port index 3 does not exist, so the write is dropped
            if (bw_port != 2'h3) begin
               nxt_out_data[bw_index] = bw_val;
            end
         end else if (reg_addr == `IOTRG_ADDR_DIR) begin
            nxt_dir = reg_wdata[2:0];
         end
      end
   end

   // per-port enable; a port pulls its pins only while its direction is output
   wire [23:0] nxt_oe;
   genvar gp;
   generate
      for (gp = 0; gp < `IOTRG_PORT_COUNT; gp = gp + 1) begin : g_port
         assign nxt_oe[gp*8 +: 8] = nxt_out_data[gp*8 +: 8] & {8{nxt_dir[gp]}};
      end
   endgenerate

   always @(posedge mclk) begin
      if (sys_rst) begin
         out_data_ff <= 24'h000000;
         port_direction_set_ff <= 3'h0;
         exp_oe_ff <= 24'h000000;
      end else if (ce) begin
         out_data_ff <= nxt_out_data;
         port_direction_set_ff <= nxt_dir;
         // pull low only for stored ones on output ports
         exp_oe_ff <= nxt_oe;
      end
   end

   // open-drain: the driven level is always low
   assign exp_out = 24'h000000;

   // direct read source, selector picks the group
   always @* begin
      case (input_read_selector_ff)
         3'h0: in_source = base_live;
         3'h1: in_source = out_data_ff;
         3'h2: in_source = exp_live;
         3'h3: in_source = {out_data_ff[23:16], exp_live[15:0]};
         3'h4: in_source = {4'h0, out_data_ff[23:16], exp_live[11:0]};
         default: in_source = 24'h000000;
      endcase
   end

   // trigger source: board 1 is the base card, others the expansion inputs
   // limitation: boards 2 to 6 share one bank, so bank bits above 15 cannot trigger
   assign trig_sample = (trigger_board_ff == `IOTRG_BOARD_BASE) ?
                        base_live[trigger_input_index_ff] :
                        exp_live[{1'b0, trigger_input_index_ff}];
   assign trig_fire = scan_tick & prog_running_ff &
                      (trigger_action_ff != `IOTRG_ACT_OFF) &
                      (trig_sample == trigger_polarity_ff);

   // self-disable on codes 3 and 4; a software write the same cycle wins
   always @* begin
      nxt_action = trigger_action_ff;
      if (trig_fire && (trigger_action_ff == `IOTRG_ACT_JMP_OFF ||
                        trigger_action_ff == `IOTRG_ACT_JMP_OFF_ABORT)) begin
         nxt_action = `IOTRG_ACT_OFF;
      end
      if (reg_wr && reg_addr == `IOTRG_ADDR_TRIG &&
          wboard >= `IOTRG_BOARD_MIN && wboard <= `IOTRG_BOARD_MAX &&
          wact <= `IOTRG_ACT_JMP_OFF_ABORT) begin
         nxt_action = wact;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         input_read_selector_ff <= 3'h0;
         input_mask_ff <= `IOTRG_INSEL_MASK_RST;
         cached_input_status_ff <= 24'h000000;
         trigger_action_ff <= `IOTRG_ACT_OFF;
         trigger_polarity_ff <= 1'b0;
         trigger_input_index_ff <= 4'h0;
         trigger_board_ff <= `IOTRG_BOARD_BASE;
         prog_running_ff <= 1'b0;
         irq_mask_ff <= {`IOTRG_IRQ_WIDTH{1'b0}};
         trig_jump_ff <= 1'b0;
         trig_abort_ff <= 1'b0;
      end else if (ce) begin
         // cache moves only on a tick; the direct read path stays live
         if (scan_tick) begin
            cached_input_status_ff <= base_live;
         end
         trigger_action_ff <= nxt_action;
         trig_jump_ff <= trig_fire;
         trig_abort_ff <= trig_fire &
                          (trigger_action_ff == `IOTRG_ACT_JMP_ABORT ||
                           trigger_action_ff == `IOTRG_ACT_JMP_OFF_ABORT);
         if (reg_wr) begin
            if (reg_addr == `IOTRG_ADDR_INSEL) begin
               // out-of-range selector leaves the old choice standing
               if (wsel <= `IOTRG_INSEL_MAX) begin
                  input_read_selector_ff <= wsel;
               end
               input_mask_ff <= reg_wdata[`IOTRG_INSEL_MASK_LSB +: 24];
            end else if (reg_addr == `IOTRG_ADDR_TRIG) begin
               if (wboard >= `IOTRG_BOARD_MIN && wboard <= `IOTRG_BOARD_MAX &&
                   wact <= `IOTRG_ACT_JMP_OFF_ABORT) begin
                  trigger_polarity_ff <= reg_wdata[`IOTRG_TRIG_POL_BIT];
                  trigger_input_index_ff <= reg_wdata[`IOTRG_TRIG_IDX_LSB +: 4];
                  trigger_board_ff <= wboard;
               end
            end else if (reg_addr == `IOTRG_ADDR_CTRL) begin
               prog_running_ff <= reg_wdata[0];
            end else if (reg_addr == `IOTRG_ADDR_IRQ_MASK) begin
               irq_mask_ff <= reg_wdata[`IOTRG_IRQ_WIDTH-1:0];
            end
         end
      end
   end

   // sticky events; read clears, but a same-cycle event survives
   always @* begin
      irq_event = {`IOTRG_IRQ_WIDTH{1'b0}};
      irq_event[`IOTRG_IRQ_FIRED] = trig_fire;
      irq_event[`IOTRG_IRQ_SCAN] = scan_tick;
      nxt_irq_stat = irq_stat_ff;
      if (reg_rd && reg_addr == `IOTRG_ADDR_IRQ_STAT) begin
         nxt_irq_stat = {`IOTRG_IRQ_WIDTH{1'b0}};
      end
      nxt_irq_stat = nxt_irq_stat | irq_event;
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         irq_stat_ff <= {`IOTRG_IRQ_WIDTH{1'b0}};
      end else if (ce) begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // level output; it drops only when software reads the status or masks it
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // read mux; unmapped offsets read zero
   always @* begin
      rd_mux = 32'h00000000;
      if (reg_addr == `IOTRG_ADDR_PORT0) begin
         rd_mux[7:0] = out_data_ff[7:0];
      end else if (reg_addr == `IOTRG_ADDR_PORT1) begin
         rd_mux[7:0] = out_data_ff[15:8];
      end else if (reg_addr == `IOTRG_ADDR_PORT2) begin
         rd_mux[7:0] = out_data_ff[23:16];
      end else if (reg_addr == `IOTRG_ADDR_DIR) begin
         rd_mux[2:0] = port_direction_set_ff;
      end else if (reg_addr == `IOTRG_ADDR_INSEL) begin
         rd_mux[`IOTRG_INSEL_SRC_LSB +: 3] = input_read_selector_ff;
         rd_mux[`IOTRG_INSEL_MASK_LSB +: 24] = input_mask_ff;
      end else if (reg_addr == `IOTRG_ADDR_INREAD) begin
         rd_mux[23:0] = in_source & input_mask_ff;
      end else if (reg_addr == `IOTRG_ADDR_CACHE) begin
         rd_mux[23:0] = cached_input_status_ff;
      end else if (reg_addr == `IOTRG_ADDR_TRIG) begin
         rd_mux[`IOTRG_TRIG_ACT_LSB +: 3] = trigger_action_ff;
         rd_mux[`IOTRG_TRIG_POL_BIT] = trigger_polarity_ff;
         rd_mux[`IOTRG_TRIG_IDX_LSB +: 4] = trigger_input_index_ff;
         rd_mux[`IOTRG_TRIG_BOARD_LSB +: 3] = trigger_board_ff;
      end else if (reg_addr == `IOTRG_ADDR_CTRL) begin
         rd_mux[0] = prog_running_ff;
      end else if (reg_addr == `IOTRG_ADDR_IRQ_STAT) begin
         rd_mux[`IOTRG_IRQ_WIDTH-1:0] = irq_stat_ff;
      end else if (reg_addr == `IOTRG_ADDR_IRQ_MASK) begin
         rd_mux[`IOTRG_IRQ_WIDTH-1:0] = irq_mask_ff;
      end
   end

   // enabled cycles load data while reg_rd is high and zero otherwise; a cycle with ce low holds the old word
   always @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata_ff <= 32'h00000000;
      end else if (ce) begin
         if (reg_rd) begin
            reg_rdata_ff <= rd_mux;
         end else begin
            reg_rdata_ff <= 32'h00000000;
         end
      end
   end

endmodule // iotrg_top

`default_nettype wire

// ===== testbench/iotrg_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "iotrg_consts.vh"
module iotrg_chk #(
   parameter integer SCAN_CYCLES = 8,
   parameter integer SCAN_CNT_W = 24
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_ff,
   input wire logic [23:0] exp_out,
   input wire logic [23:0] exp_oe_ff,
   input wire logic trig_jump_ff,
   input wire logic trig_abort_ff,
   input wire logic irq
);
   int gap_ff;
   // saturating gap since last jump, so spacing is checked without a long repetition
   always @(posedge mclk) begin
      if (sys_rst || trig_jump_ff) gap_ff <= 0;
      else if (ce && gap_ff < 1000) gap_ff <= gap_ff + 1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_out_low; exp_out == 24'h0; endproperty
   a_out_low: assert property (p_out_low) else $error("pin driven high");
   property p_rst_idle;
      disable iff (1'b0) sys_rst && ce |=> exp_oe_ff == 24'h0 && !trig_jump_ff && !irq;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("reset left pins active");
   property p_abort_jump; trig_abort_ff |-> trig_jump_ff; endproperty
   a_abort_jump: assert property (p_abort_jump) else $error("abort without jump");
   property p_scan_gap; trig_jump_ff |-> gap_ff >= SCAN_CYCLES - 1; endproperty
   a_scan_gap: assert property (p_scan_gap) else $error("trigger faster than scan");
   property p_zero_release;
      ce && reg_wr && reg_addr == `IOTRG_ADDR_PORT0 && reg_wdata[7:0] == 8'h00
         |=> exp_oe_ff[7:0] == 8'h00;
   endproperty
   a_zero_release: assert property (p_zero_release) else $error("zero data drives pin");
   property p_dir_input;
      ce && reg_wr && reg_addr == `IOTRG_ADDR_DIR && reg_wdata[2:0] == 3'h0 |=> exp_oe_ff == 24'h0;
   endproperty
   a_dir_input: assert property (p_dir_input) else $error("input port drives pin");
   property p_oe_hold; ce && !reg_wr |=> $stable(exp_oe_ff); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("enables moved without write");
   property p_rd_idle; ce && !reg_rd |=> reg_rdata_ff == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_bit_keep;
      ce && reg_wr && reg_addr == `IOTRG_ADDR_BITWR && reg_wdata[5:4] == 2'h0
         |=> ((exp_oe_ff ^ $past(exp_oe_ff)) & ~(24'h1 << $past(reg_wdata[2:0]))) == 24'h0;
   endproperty
   a_bit_keep: assert property (p_bit_keep) else $error("bit write touched others");
endmodule // iotrg_chk
bind iotrg_top iotrg_chk #(.SCAN_CYCLES(SCAN_CYCLES), .SCAN_CNT_W(SCAN_CNT_W)) iotrg_chk_inst (
   .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .exp_out(exp_out),
   .exp_oe_ff(exp_oe_ff), .trig_jump_ff(trig_jump_ff), .trig_abort_ff(trig_abort_ff),
   .irq(irq));
`default_nettype wire

// ===== testbench/iotrg_field.sv
`timescale 1ns/1ps
`default_nettype none
// switches and loads on the connector; every bank pin has a pull-up
module iotrg_field (
   input wire logic [23:0] exp_out,
   input wire logic [23:0] exp_oe_ff,
   input wire logic [23:0] sw_open,
   input wire logic [15:0] base_sw,
   output logic [23:0] exp_in,
   output logic [15:0] base_in
);
   // a closed switch or an enabled driver wins over the pull-up
   assign exp_in = sw_open & ~(exp_oe_ff & ~exp_out);
   assign base_in = base_sw;
endmodule // iotrg_field
`default_nettype wire

// ===== testbench/tb_io_ports_input_trigger.sv
`timescale 1ns/1ps
`default_nettype none
`include "iotrg_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_io_ports_input_trigger;
   logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ce = 1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, rd_val;
   logic [31:0] reg_rdata_ff;
   logic [15:0] base_in, base_sw = 16'hFFFE;
   logic [23:0] exp_in, exp_out, exp_oe_ff, sw_open = 24'hFFFFFF;
   logic trig_jump_ff, trig_abort_ff, irq, ab, got;
   int err_count = 0, tests_run = 0;
   always #5 mclk = ~mclk;
   iotrg_top #(.SCAN_CYCLES(8), .SCAN_CNT_W(4)) iotrg_top_inst (
      .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .base_in(base_in),
      .exp_in(exp_in), .exp_out(exp_out), .exp_oe_ff(exp_oe_ff), .trig_jump_ff(trig_jump_ff),
      .trig_abort_ff(trig_abort_ff), .irq(irq));
   iotrg_field iotrg_field_inst (.exp_out(exp_out), .exp_oe_ff(exp_oe_ff), .sw_open(sw_open),
      .base_sw(base_sw), .exp_in(exp_in), .base_in(base_in));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // callers look at outputs only once the write has settled
      @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      rd_val = reg_rdata_ff;
      `CHK(rd_val, exp)
   endtask
   task automatic wait_jump(output logic abt, output logic seen);
      seen = 0;
      abt = 0;
      for (int i = 0; i < 24 && !seen; i++) begin
         @(negedge mclk);
         if (trig_jump_ff === 1'b1) begin
            seen = 1;
            abt = trig_abort_ff;
         end
      end
   endtask
   task automatic end_of_test;
      if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      `CHK(exp_oe_ff, 24'h0)
      rd(`IOTRG_ADDR_DIR, 32'h0);
      rd(`IOTRG_ADDR_INSEL, 32'hFFFFFF00);
      // data stored while the port is still an input must not reach the pin
      wr(`IOTRG_ADDR_PORT0, 32'hA5);
      rd(`IOTRG_ADDR_PORT0, 32'hA5);
      `CHK(exp_oe_ff, 24'h0)
      wr(`IOTRG_ADDR_DIR, 32'h1);
      `CHK(exp_oe_ff, 24'h0000A5)
      wr(`IOTRG_ADDR_PORT2, 32'hFF);
      `CHK(exp_oe_ff, 24'h0000A5)
      repeat (6) @(posedge mclk);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF02);
      rd(`IOTRG_ADDR_INREAD, 32'hFFFF5A);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF01);
      rd(`IOTRG_ADDR_INREAD, 32'hFF00A5);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF03);
      rd(`IOTRG_ADDR_INREAD, 32'hFFFF5A);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF04);
      rd(`IOTRG_ADDR_INREAD, 32'h0FFF5A);
      wr(`IOTRG_ADDR_INSEL, 32'h00000302);
      rd(`IOTRG_ADDR_INREAD, 32'h000002);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF05);
      rd(`IOTRG_ADDR_INSEL, 32'hFFFFFF02);
      wr(`IOTRG_ADDR_BITWR, 32'h100);
      `CHK(exp_oe_ff, 24'h0000A5)
      wr(`IOTRG_ADDR_BITWR, 32'h005);
      rd(`IOTRG_ADDR_PORT0, 32'h85);
      `CHK(exp_oe_ff, 24'h000085)
      wr(`IOTRG_ADDR_BITWR, 32'h136);
      rd(`IOTRG_ADDR_PORT2, 32'hFF);
      wr(`IOTRG_ADDR_PORT0, 32'h00);
      wr(`IOTRG_ADDR_DIR, 32'h0);
      rd(8'h3C, 32'h0);
      @(posedge mclk);
      base_sw <= 16'h1234;
      repeat (20) @(posedge mclk);
      wr(`IOTRG_ADDR_INSEL, 32'hFFFFFF00);
      rd(`IOTRG_ADDR_INREAD, 32'h1234);
      rd(`IOTRG_ADDR_CACHE, 32'h1234);
      // program stopped: a matching level must be ignored
      wr(`IOTRG_ADDR_TRIG, 32'h101);
      wait_jump(ab, got);
      `CHK(got, 1'b0)
      wr(`IOTRG_ADDR_TRIG, 32'h109);
      wr(`IOTRG_ADDR_CTRL, 32'h1);
      wait_jump(ab, got);
      `CHK(got, 1'b0)
      wr(`IOTRG_ADDR_TRIG, 32'h70A);
      rd(`IOTRG_ADDR_TRIG, 32'h109);
      wr(`IOTRG_ADDR_TRIG, 32'h149);
      wait_jump(ab, got);
      `CHK(got, 1'b1)
      for (int act = 1; act <= 4; act++) begin
         wr(`IOTRG_ADDR_TRIG, 32'h100 | act);
         wait_jump(ab, got);
         `CHK(got, 1'b1)
         `CHK(ab, (act == 1 || act == 4))
         if (act == 1) begin
            `CHK(irq, 1'b0)
            wr(`IOTRG_ADDR_IRQ_MASK, 32'h1);
            `CHK(irq, 1'b1)
         end
         rd(`IOTRG_ADDR_TRIG, (act >= 3) ? 32'h100 : 32'h100 | act);
      end
      rd(`IOTRG_ADDR_IRQ_STAT, 32'h3);
      @(negedge mclk);
      `CHK(irq, 1'b0)
      // frozen clock enable: a write in that window must not land
      @(posedge mclk);
      ce <= 1'b0;
      wr(`IOTRG_ADDR_PORT1, 32'h3C);
      @(posedge mclk);
      ce <= 1'b1;
      rd(`IOTRG_ADDR_PORT1, 32'h0);
      wr(`IOTRG_ADDR_PORT1, 32'h3C);
      rd(`IOTRG_ADDR_PORT1, 32'h3C);
      wr(`IOTRG_ADDR_TRIG, 32'h200);
      @(posedge mclk);
      sw_open <= 24'hFFFFFE;
      wr(`IOTRG_ADDR_TRIG, 32'h202);
      wait_jump(ab, got);
      `CHK(got, 1'b1)
      end_of_test;
   end
endmodule // tb_io_ports_input_trigger
`default_nettype wire
